// file: hw/intc_pkg.sv
// Purpose: shared constants and types of the vectored interrupt unit
// Assumes: APB slave, 32-bit data, byte addresses on a 12-bit bus
// Notes: one aligned word per register
`default_nettype none
package intc_pkg;
	localparam int NUM_SRC = 32;
	localparam int SRC_FAST = 0;
	localparam int SRC_SYS = 1;
	localparam int SRC_EXT = 31;
	localparam int PERIPH_LO = 2;
	localparam int PERIPH_HI = 24;
	localparam int NUM_SYS = 8;
	localparam int ADDR_W = 12;
	localparam logic [3:0] NEST_DEPTH = 4'h8;
	// register byte offsets
	localparam logic [ADDR_W-1:0] MODE_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] VEC_BASE = 12'h080;
	localparam logic [ADDR_W-1:0] CTRL_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_IVR = 12'h100;
	localparam logic [ADDR_W-1:0] OFF_FVR = 12'h104;
	localparam logic [ADDR_W-1:0] OFF_CUR = 12'h108;
	localparam logic [ADDR_W-1:0] OFF_PEND = 12'h10c;
	localparam logic [ADDR_W-1:0] OFF_MASK = 12'h110;
	localparam logic [ADDR_W-1:0] OFF_MSET = 12'h114;
	localparam logic [ADDR_W-1:0] OFF_MCLR = 12'h118;
	localparam logic [ADDR_W-1:0] OFF_PCLR = 12'h11c;
	localparam logic [ADDR_W-1:0] OFF_PSET = 12'h120;
	localparam logic [ADDR_W-1:0] OFF_EOI = 12'h124;
	localparam logic [ADDR_W-1:0] OFF_FFSET = 12'h128;
	localparam logic [ADDR_W-1:0] OFF_FFCLR = 12'h12c;
	localparam logic [ADDR_W-1:0] OFF_FFSTAT = 12'h130;
	localparam logic [ADDR_W-1:0] OFF_PROT = 12'h134;
	localparam logic [ADDR_W-1:0] OFF_CKSET = 12'h140;
	localparam logic [ADDR_W-1:0] OFF_CKCLR = 12'h144;
	localparam logic [ADDR_W-1:0] OFF_CKSTAT = 12'h148;
	// bit masks and reset values
	localparam logic [31:0] RSV_MASK = 32'h7e00_0000;
	localparam logic [31:0] CLK_LOCK_MASK = 32'h8080_0003;
	localparam logic [31:0] CLK_RST = 32'h0000_0002;
	localparam logic [31:0] FAST_BIT = 32'h0000_0001;
	localparam int PROT_BIT = 0;
	// trig[1]: active high / rising, trig[0]: edge mode
	typedef struct packed {
		logic [1:0] trig;
		logic [2:0] prio;
	} srcmode_t;
	localparam srcmode_t MODE_RST = 5'h00;
	typedef struct packed {
		logic valid;
		logic [4:0] src;
		logic [2:0] prio;
	} winner_t;
endpackage : intc_pkg
`default_nettype wire

// file: hw/src_detect.sv
// Purpose: per-source detector and pending flag
// Assumes: srcLevel already in the sys_clk domain
// Notes: internal sources ignore the polarity bit
`timescale 1ns/100ps
`default_nettype none
module src_detect (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic srcLevel,
	input wire logic [1:0] trig,
	input wire logic internalSrc,
	input wire logic setPend,
	input wire logic clrPend,
	output logic pending
);
	logic active;
	logic activePrev_q, activePrev_d;
	logic pend_q, pend_d;

	// active level, polarity fixed positive for internal sources
	always_comb begin
		active = (internalSrc || trig[1]) ? srcLevel : !srcLevel;
		activePrev_d = active;
		if (trig[0]) begin
			// edge: sticky, a new edge wins over a clear
			if ((active && !activePrev_q) || setPend) begin
				pend_d = 1'b1;
			end else if (clrPend) begin
				pend_d = 1'b0;
			end else begin
				pend_d = pend_q;
			end
		end else begin
			pend_d = active || setPend; // level follows the line
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			activePrev_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			activePrev_q <= activePrev_d;
			pend_q <= pend_d;
		end
	end

	assign pending = pend_q;
endmodule : src_detect
`default_nettype wire

// file: hw/vectored_interrupt_unit.sv
// Purpose: vectored, prioritised interrupt unit with APB registers
// Assumes: sys_clk 200 MHz, nrst asynchronous active low
// Notes: pins pass two flops; APB answers one cycle after setup
// Contract
// - drive active-low normal and fast request lines to the core
// - thirty-two sources, each maskable with its own vector
// - source zero is the external fast input on the fast path
// - source one is the OR of eight system unit interrupts
// - internal sources choose edge or level detection
// - external sources choose rising, falling, high or low
// - two external inputs: fast on source zero, normal on 31
// - eight-level priority over sources 1 to 31 drives normal request
// - nesting: strictly higher pending priority still raises request
// - one writable 32-bit vector register per source
// - vector read returns vector of the source chosen for service
// - protect mode stops reads from changing interrupt state
// - fast forcing moves selected sources onto the fast request
// - source equals peripheral number; 25 to 30 never assert
// - source one only inside this unit, its clocks never gated
// - clock enable and disable ignore bits 0, 1, 23 and 31
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_unit
	import intc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic externalFastInput,
	input wire logic externalNormalInput,
	input wire logic [NUM_SRC-1:0] periphIrq,
	input wire logic [NUM_SYS-1:0] sysUnitIrq,
	output logic normalRequestOutN,
	output logic fastRequestOutN,
	output logic [31:0] powerManagerClkEn
);
	logic fastMeta_q, fastMeta_d, fastSync_q, fastSync_d;
	logic normMeta_q, normMeta_d, normSync_q, normSync_d;
	logic [NUM_SRC-1:0] rawSrc, pendVec, setVec, clrVec, cand;
	srcmode_t modeQ [NUM_SRC];
	srcmode_t modeD [NUM_SRC];
	logic [31:0] vecQ [NUM_SRC];
	logic [31:0] vecD [NUM_SRC];
	logic [31:0] maskQ, maskD, ffeQ, ffeD, clkQ, clkD;
	logic protQ, protD;
	logic [2:0] lvlStackQ [NEST_DEPTH];
	logic [2:0] lvlStackD [NEST_DEPTH];
	logic [4:0] srcStackQ [NEST_DEPTH];
	logic [4:0] srcStackD [NEST_DEPTH];
	logic [3:0] spQ, spD, spM1;
	winner_t win, ackQ, ackD;
	logic irqCond, fastCond, setup, rdDone, wrDone, doAck, doEoi, mapped;
	logic [31:0] prdata_q, prdata_d, rdMux;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic normReqN_q, normReqN_d, fastReqN_q, fastReqN_d;
	logic [2:0] topLvl;
	logic [4:0] topSrc;
	logic tieLower;

	// two-flop synchronisers on the external pins
	always_comb begin
		fastMeta_d = externalFastInput;
		fastSync_d = fastMeta_q;
		normMeta_d = externalNormalInput;
		normSync_d = normMeta_q;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fastMeta_q <= 1'b1; // idle high, no false event
			fastSync_q <= 1'b1;
			normMeta_q <= 1'b1;
			normSync_q <= 1'b1;
		end else begin
			fastMeta_q <= fastMeta_d;
			fastSync_q <= fastSync_d;
			normMeta_q <= normMeta_d;
			normSync_q <= normSync_d;
		end
	end

	// source map by peripheral number
	always_comb begin
		rawSrc = '0;
		rawSrc[SRC_FAST] = fastSync_q;
		rawSrc[SRC_SYS] = |sysUnitIrq;
		rawSrc[PERIPH_HI:PERIPH_LO] = periphIrq[PERIPH_HI:PERIPH_LO];
		rawSrc[SRC_EXT] = normSync_q;
	end

	// one detector per source
	for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
		src_detect u_det (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.srcLevel(rawSrc[g]),
			.trig(modeQ[g].trig),
			.internalSrc(g != SRC_FAST && g != SRC_EXT),
			.setPend(setVec[g]),
			.clrPend(clrVec[g]),
			.pending(pendVec[g])
		);
	end

	// bus phase decode
	assign setup = psel && !penable;
	assign rdDone = psel && penable && pready_q && !pwrite;
	assign wrDone = psel && penable && pready_q && pwrite && mapped;
	assign doAck = (paddr == OFF_IVR) && ((rdDone && !protQ) || (wrDone && protQ));
	assign doEoi = wrDone && (paddr == OFF_EOI);
	assign spM1 = spQ - 4'h1;
	assign topLvl = lvlStackQ[spM1[2:0]];
	assign topSrc = (spQ != '0) ? srcStackQ[spM1[2:0]] : '0;

	// arbitration: highest level, lower number on a tie
	always_comb begin
		cand = pendVec & maskQ & ~ffeQ & ~FAST_BIT;
		win = '0;
		for (int i = NUM_SRC - 1; i > SRC_FAST; i--) begin
			if (cand[i] && (!win.valid || modeQ[i].prio >= win.prio)) begin
				win.valid = 1'b1;
				win.src = 5'(i);
				win.prio = modeQ[i].prio;
			end
		end
		irqCond = win.valid && (spQ == '0 || win.prio > topLvl);
		fastCond = |(pendVec & maskQ & (ffeQ | FAST_BIT));
		normReqN_d = !irqCond;
		fastReqN_d = !fastCond;
	end

	// software set and clear of pending flags
	always_comb begin
		setVec = '0;
		clrVec = '0;
		if (wrDone && paddr == OFF_PSET) begin
			setVec = pwdata & ~RSV_MASK;
		end
		if (wrDone && paddr == OFF_PCLR) begin
			clrVec = pwdata;
		end
		if (doAck && ackQ.valid) begin
			clrVec = clrVec | (32'h1 << ackQ.src);
		end
		if (rdDone && paddr == OFF_FVR && !protQ) begin
			clrVec = clrVec | FAST_BIT;
		end
	end

	// nesting stack of serviced levels
	always_comb begin
		spD = spQ;
		lvlStackD = lvlStackQ;
		srcStackD = srcStackQ;
		if (doAck && ackQ.valid && spQ < NEST_DEPTH) begin
			lvlStackD[spQ[2:0]] = ackQ.prio;
			srcStackD[spQ[2:0]] = ackQ.src;
			spD = spQ + 4'h1;
		end else if (doEoi && spQ != '0) begin
			spD = spM1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			spQ <= '0;
			for (int i = 0; i < NEST_DEPTH; i++) begin
				lvlStackQ[i] <= '0;
				srcStackQ[i] <= '0;
			end
		end else begin
			spQ <= spD;
			lvlStackQ <= lvlStackD;
			srcStackQ <= srcStackD;
		end
	end

	// register writes
	always_comb begin
		modeD = modeQ;
		vecD = vecQ;
		maskD = maskQ;
		ffeD = ffeQ;
		clkD = clkQ;
		protD = protQ;
		if (wrDone && paddr < VEC_BASE) begin
			modeD[paddr[6:2]] = srcmode_t'({pwdata[6:5], pwdata[2:0]});
		end
		if (wrDone && paddr >= VEC_BASE && paddr < CTRL_BASE) begin
			vecD[paddr[6:2]] = pwdata;
		end
		if (wrDone) begin
			unique case (paddr)
				OFF_MSET: maskD = maskQ | (pwdata & ~RSV_MASK);
				OFF_MCLR: maskD = maskQ & ~pwdata;
				OFF_FFSET: ffeD = ffeQ | (pwdata & ~FAST_BIT);
				OFF_FFCLR: ffeD = ffeQ & ~pwdata;
				OFF_PROT: protD = pwdata[PROT_BIT];
				OFF_CKSET: clkD = clkQ | (pwdata & ~CLK_LOCK_MASK);
				OFF_CKCLR: clkD = clkQ & ~(pwdata & ~CLK_LOCK_MASK);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				modeQ[i] <= MODE_RST;
				vecQ[i] <= '0;
			end
			maskQ <= '0;
			ffeQ <= '0;
			clkQ <= CLK_RST;
			protQ <= 1'b0;
		end else begin
			modeQ <= modeD;
			vecQ <= vecD;
			maskQ <= maskD;
			ffeQ <= ffeD;
			clkQ <= clkD;
			protQ <= protD;
		end
	end

	// read mux; vector read shows the winner taken at setup
	always_comb begin
		rdMux = '0;
		mapped = 1'b1;
		if (paddr < VEC_BASE) begin
			rdMux = {25'h0, modeQ[paddr[6:2]].trig, 2'h0, modeQ[paddr[6:2]].prio};
		end else if (paddr < CTRL_BASE) begin
			rdMux = vecQ[paddr[6:2]];
		end else begin
			unique case (paddr)
				OFF_IVR: rdMux = irqCond ? vecQ[win.src] : '0;
				OFF_FVR: rdMux = vecQ[SRC_FAST];
				OFF_CUR: rdMux = {27'h0, topSrc};
				OFF_PEND: rdMux = pendVec;
				OFF_MASK: rdMux = maskQ;
				OFF_FFSTAT: rdMux = ffeQ;
				OFF_PROT: rdMux = {31'h0, protQ};
				OFF_CKSTAT: rdMux = clkQ;
				OFF_MSET, OFF_MCLR, OFF_PCLR, OFF_PSET, OFF_EOI,
				OFF_FFSET, OFF_FFCLR, OFF_CKSET, OFF_CKCLR: rdMux = '0;
				default: mapped = 1'b0;
			endcase
		end
		if (paddr[1:0] != 2'h0 || paddr > OFF_CKSTAT) begin
			mapped = 1'b0;
			rdMux = '0;
		end
	end

	// APB answer: one wait-free access phase after setup
	always_comb begin
		pready_d = setup;
		pslverr_d = setup && !mapped;
		prdata_d = setup ? rdMux : prdata_q;
		ackD = ackQ;
		if (setup) begin
			ackD = win;
			ackD.valid = irqCond;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			ackQ <= '0;
			normReqN_q <= 1'b1;
			fastReqN_q <= 1'b1;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
			ackQ <= ackD;
			normReqN_q <= normReqN_d;
			fastReqN_q <= fastReqN_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign normalRequestOutN = normReqN_q;
	assign fastRequestOutN = fastReqN_q;
	assign powerManagerClkEn = clkQ;

	// checks
	a_fast_source0: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		pendVec[SRC_FAST] && maskQ[SRC_FAST] |=> !fastRequestOutN)
		else $error("fast source did not raise fast request");
	a_masked_quiet: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!normalRequestOutN |-> $past(|(pendVec & maskQ)))
		else $error("normal request without unmasked pending source");
	a_reserved_idle: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(pendVec & RSV_MASK) == '0)
		else $error("reserved source became pending");
	a_clock_locked: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(clkQ & CLK_LOCK_MASK) == CLK_RST)
		else $error("locked clock enable bit changed");
	a_nest_raise: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		spQ != '0 && win.valid && win.prio > topLvl |=> !normalRequestOutN)
		else $error("higher level not raised during service");
	a_protect_hold: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		protQ && rdDone && paddr == OFF_IVR |=> spQ == $past(spQ))
		else $error("vector read changed state in protect mode");
	a_forced_fast: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		|(pendVec & maskQ & ffeQ) |=> !fastRequestOutN)
		else $error("forced source did not reach fast request");
	a_ack_push: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		doAck && ackQ.valid && spQ < NEST_DEPTH |=> spQ == $past(spQ) + 4'h1
		##0 topSrc == $past(ackQ.src))
		else $error("acknowledge did not push the served source");

	// helper: a lower-numbered candidate sits at the winning level
	always_comb begin
		tieLower = 1'b0;
		for (int j = SRC_SYS; j < NUM_SRC; j++) begin
			if (cand[j] && modeQ[j].prio == win.prio
				&& 5'(j) < win.src) begin
				tieLower = 1'b1;
			end
		end
	end

	a_tie_lower: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		win.valid |-> !tieLower)
		else $error("tie not resolved to the lower source");
	a_apb_one_wait: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		setup |=> pready ##1 !pready)
		else $error("access phase length wrong");
endmodule : vectored_interrupt_unit
`default_nettype wire

// file: verif/core_model.sv
// Purpose: processor core stand-in that watches both request lines
// Assumes: request lines are active-low levels launched from flops
// Notes: counts each fresh assertion so the bench sees the core react
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic normalRequestOutN,
	input wire logic fastRequestOutN,
	output logic [7:0] irqCount,
	output logic [7:0] fastCount
);
	logic irqPrevQ;
	logic fastPrevQ;
	// count falling edges of each active-low request line
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irqPrevQ <= 1'b1;
			fastPrevQ <= 1'b1;
			irqCount <= 8'h00;
			fastCount <= 8'h00;
		end else begin
			irqPrevQ <= normalRequestOutN;
			fastPrevQ <= fastRequestOutN;
			if (irqPrevQ && !normalRequestOutN) begin
				irqCount <= irqCount + 8'h01;
			end
			if (fastPrevQ && !fastRequestOutN) begin
				fastCount <= fastCount + 8'h01;
			end
		end
	end
endmodule : core_model
`default_nettype wire

// file: verif/tb.sv
// Purpose: self-checking bench of the vectored interrupt unit
// Assumes: APB answers with pready, inputs change just after rising edges
// Notes: random vectors and clock masks come from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin \
	nErrors++; $display("wrong value %s expected %h seen %h", nm, e, g); \
	end end
module tb;
	import intc_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic externalFastInput = 1'b1;
	logic externalNormalInput = 1'b1;
	logic [NUM_SRC-1:0] periphIrq = '0;
	logic [NUM_SYS-1:0] sysUnitIrq = '0;
	logic normalRequestOutN;
	logic fastRequestOutN;
	logic [31:0] powerManagerClkEn;
	logic [7:0] irqCount;
	logic [7:0] fastCount;
	logic [31:0] vecs [NUM_SRC];
	int nErrors = 0;
	int numChecks = 0;
	int cyc = 0;
	vectored_interrupt_unit uut (.sys_clk(sys_clk), .nrst(nrst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .externalFastInput(externalFastInput),
		.externalNormalInput(externalNormalInput), .periphIrq(periphIrq),
		.sysUnitIrq(sysUnitIrq), .normalRequestOutN(normalRequestOutN),
		.fastRequestOutN(fastRequestOutN),
		.powerManagerClkEn(powerManagerClkEn));
	core_model core (.sys_clk(sys_clk), .nrst(nrst),
		.normalRequestOutN(normalRequestOutN),
		.fastRequestOutN(fastRequestOutN), .irqCount(irqCount),
		.fastCount(fastCount));
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	// mode word: polarity bit6, edge bit5, priority bits 2:0
	function automatic logic [31:0] modeW(input logic pol, input logic edg,
		input logic [2:0] pr);
		return {25'h0, pol, edg, 2'b00, pr};
	endfunction : modeW
	// locked clock bits: source one stays on, 0, 23 and 31 stay off
	function automatic logic [31:0] clkW(input logic [31:0] v);
		return (v & ~CLK_LOCK_MASK) | CLK_RST;
	endfunction : clkW
	// one APB transfer, held until pready, then one idle edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask : wr
	task automatic rdChk(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		logic [31:0] x;
		logic er;
		apb(1'b0, a, 32'h0, x, er);
		`CHK(nm, e, x)
	endtask : rdChk
	// wait a bounded time for a request line to reach a level
	task automatic waitOut(input bit fast, input logic e);
		int n = 0;
		while ((fast ? fastRequestOutN : normalRequestOutN) !== e && n < 12)
		begin
			@(posedge sys_clk);
			n++;
		end
		`CHK(fast ? "fast line" : "normal line", e,
			fast ? fastRequestOutN : normalRequestOutN)
	endtask : waitOut
	task automatic results();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			nErrors++;
			results();
		end
	end
	// main sequence
	initial begin
		logic [31:0] r;
		logic er;
		int k;
		void'($urandom(32'h85b98312));
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		`CHK("clk reset", CLK_RST, powerManagerClkEn)
		`CHK("normal idle", 1'b1, normalRequestOutN)
		rdChk("mask reset", OFF_MASK, 32'h0);
		for (int i = 0; i < NUM_SRC; i++) begin
			vecs[i] = $urandom;
			wr(VEC_BASE + 12'(4 * i), vecs[i]);
		end
		for (int i = 0; i < 3; i++) begin
			k = $urandom_range(31);
			rdChk("vector", VEC_BASE + 12'(4 * k), vecs[k]);
		end
		// tie at level 3, nested level 6
		wr(MODE_BASE + 12'h014, modeW(1'b0, 1'b0, 3'h3));
		wr(MODE_BASE + 12'h024, modeW(1'b0, 1'b0, 3'h3));
		wr(MODE_BASE + 12'h030, modeW(1'b0, 1'b0, 3'h6));
		wr(OFF_MSET, 32'h0000_1220);
		periphIrq <= 32'h0000_0220;
		waitOut(0, 1'b0);
		rdChk("tie vector", OFF_IVR, vecs[5]);
		repeat (6) @(posedge sys_clk);
		waitOut(0, 1'b1);
		periphIrq <= 32'h0000_1220;
		waitOut(0, 1'b0);
		rdChk("nested vector", OFF_IVR, vecs[12]);
		rdChk("current source", OFF_CUR, 32'd12);
		wr(OFF_FFSET, 32'h0000_1000);
		waitOut(1, 1'b0);
		wr(OFF_FFCLR, 32'h0000_1000);
		periphIrq <= '0;
		wr(OFF_EOI, 32'h0);
		wr(OFF_EOI, 32'h0);
		waitOut(1, 1'b1);
		// protect mode: reads leave the stack alone
		wr(OFF_PROT, 32'h1);
		periphIrq <= 32'h0000_0020;
		waitOut(0, 1'b0);
		rdChk("protect vector", OFF_IVR, vecs[5]);
		rdChk("stack kept", OFF_CUR, 32'h0);
		wr(OFF_IVR, 32'h0);
		rdChk("protect ack", OFF_CUR, 32'd5);
		wr(OFF_EOI, 32'h0);
		wr(OFF_PROT, 32'h0);
		periphIrq <= '0;
		// masked edge event on source 7
		wr(MODE_BASE + 12'h01c, modeW(1'b0, 1'b1, 3'h2));
		periphIrq <= 32'h0000_0080;
		@(posedge sys_clk);
		periphIrq <= '0;
		repeat (6) @(posedge sys_clk);
		waitOut(0, 1'b1);
		rdChk("held event", OFF_PEND, 32'h0000_0080);
		wr(OFF_MSET, 32'h0000_0080);
		waitOut(0, 1'b0);
		wr(OFF_PCLR, 32'h0000_0080);
		wr(OFF_MCLR, 32'h0000_0080);
		// reserved numbers never assert
		periphIrq <= RSV_MASK;
		wr(OFF_PSET, RSV_MASK);
		wr(OFF_MSET, RSV_MASK);
		rdChk("reserved pend", OFF_PEND, 32'h0);
		rdChk("reserved mask", OFF_MASK, 32'h0000_1220);
		waitOut(0, 1'b1);
		periphIrq <= '0;
		sysUnitIrq <= 8'h01 << $urandom_range(7);
		repeat (4) @(posedge sys_clk);
		rdChk("system source", OFF_PEND, 32'h0000_0002);
		sysUnitIrq <= '0;
		// source 31: low, falling, high, rising
		for (int t = 0; t < 4; t++) begin
			externalNormalInput <= ~t[1];
			wr(MODE_BASE + 12'h07c, modeW(t[1], t[0], 3'h1));
			repeat (6) @(posedge sys_clk);
			wr(OFF_PCLR, 32'h8000_0000);
			rdChk("ext idle", OFF_PEND, 32'h0);
			externalNormalInput <= t[1];
			repeat (6) @(posedge sys_clk);
			rdChk("ext active", OFF_PEND, 32'h8000_0000);
		end
		externalNormalInput <= 1'b1;
		wr(MODE_BASE + 12'h07c, 32'h0);
		wr(OFF_PCLR, 32'h8000_0000);
		// source zero on the fast line
		wr(OFF_MSET, FAST_BIT);
		externalFastInput <= 1'b0;
		waitOut(1, 1'b0);
		`CHK("normal quiet", 1'b1, normalRequestOutN)
		rdChk("fast vector", OFF_FVR, vecs[0]);
		externalFastInput <= 1'b1;
		wr(OFF_MCLR, FAST_BIT);
		waitOut(1, 1'b1);
		// clock enables ignore locked bits
		r = $urandom;
		wr(OFF_CKSET, r);
		rdChk("clk status", OFF_CKSTAT, clkW(r));
		`CHK("clk pins", clkW(r), powerManagerClkEn)
		wr(OFF_CKCLR, 32'hffff_ffff);
		rdChk("clk cleared", OFF_CKSTAT, CLK_RST);
		apb(1'b0, 12'hffc, 32'h0, r, er);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0, r)
		apb(1'b1, MODE_BASE + 12'h006, 32'h0000_0007, r, er);
		`CHK("misaligned err", 1'b1, er)
		rdChk("misaligned kept", MODE_BASE + 12'h004, 32'h0);
		`CHK("core irq", 1'b1, irqCount != 8'h00)
		`CHK("core fast", 1'b1, fastCount != 8'h00)
		results();
	end
endmodule : tb
`default_nettype wire
